// [ipg_cmd_core.sv]
// command handling for idle, idle immediate and geometry commands
// Operation
// (RQ1) timed idle: idle now, load, start timer
// (RQ2) spin up on idle unless already spinning
// (RQ3) idle keeps spinning, commands answered immediately
// (RQ4) zero timeout disables power-down, nonzero enables
// (RQ5) timeout code decoded per table
// (RQ6) expiry without access drops to standby
// (RQ7) host access reloads full interval
// (RQ8) immediate idle enters idle, spins up
// (RQ9) immediate idle keeps stored timeout
// (RQ10) geometry command stores sectors and heads
// (RQ11) stored geometry shown to identify data
// (RQ12) geometry kept unless revert option soft reset
// (RQ13) zero sectors means zero sectors
// (RQ14) heads minus one is four bits
// (RQ15) host keeps cylinder count in limit
// (RQ16) only abort reported; status at completion
// (RQ17) host sets device/head before opcode
// (RQ18) state kept internally; unused fields ignored
`timescale 1ns/100ps
`include "ipg_defines.svh"
module ipg_cmd_core #(
  parameter int unsigned TICK_CYCLES   = `IPG_TICK_CYCLES,
  parameter int unsigned SPINUP_CYCLES = `IPG_SPINUP_CYCLES
) (
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            resetn,
  // register port
  input  wire ipg_pkg::ipg_bus_s bus,
  output logic [7:0]           rdata,
  // drive side
  input  wire logic            soft_reset,
  input  wire logic            spindle_spinning,
  output logic                 spin_up_req,
  output logic                 in_standby,
  output ipg_pkg::ipg_geom_s   id_geometry,
  // interrupt
  output logic                 irq
);
  import ipg_pkg::*;

  logic        rst_s1_r;
  logic        rst_n;
  logic [7:0]  seccnt_r;
  logic [7:0]  devhead_r;
  logic [7:0]  timeout_r;
  logic [7:0]  retain_r;
  logic        abort_r;
  logic        busy_r;
  logic        rdy_r;
  logic        err_r;
  ipg_power_e  power_r;
  ipg_geom_s   geom_r;
  logic [31:0] spin_cnt_r;
  logic [2:0]  irq_stat_r;
  logic [2:0]  irq_mask_r;
  logic        cmd_wr;
  logic        host_access;
  logic        timer_reload;
  logic        expire;
  logic        spun_ev;
  logic [7:0]  op;
  logic        is_idle;
  logic        is_imm;
  logic        is_geom;
  logic [2:0]  ev;

  // reset release through two flops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  assign op          = bus.wdata;
  assign cmd_wr      = bus.wr && bus.addr == `IPG_ADDR_CMD;
  assign is_idle     = cmd_wr && (op == `IPG_OP_IDLE_A || op == `IPG_OP_IDLE_B);
  assign is_imm      = cmd_wr && (op == `IPG_OP_IDLE_IMM_A || op == `IPG_OP_IDLE_IMM_B);
  assign is_geom     = cmd_wr && op == `IPG_OP_GEOM;
  // reads and writes of command, sector count and device/head count as drive access
  assign host_access = (bus.wr || bus.rd) && bus.addr <= `IPG_ADDR_DEVHEAD;
  assign timer_reload = host_access; // see (RQ7)

  // task file fields latched from host writes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      seccnt_r  <= 8'h00;
      devhead_r <= 8'hA0;
    end else if (bus.wr) begin
      if (bus.addr == `IPG_ADDR_SECCNT) seccnt_r <= bus.wdata;
      if (bus.addr == `IPG_ADDR_DEVHEAD) devhead_r <= bus.wdata; // see (RQ17)
    end
  end

  // timeout parameter only touched by the timed idle command
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) timeout_r <= 8'h00;
    else if (is_idle) timeout_r <= seccnt_r; // see (RQ1) see (RQ9) see (RQ18)
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) retain_r <= `IPG_RETAIN_KEEP;
    else if (bus.wr && bus.addr == `IPG_ADDR_CTRL) retain_r <= bus.wdata;
  end

  // geometry; only head field of device/head used
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) geom_r <= '0;
    else if (is_geom) begin
      geom_r.sectors  <= seccnt_r;          // see (RQ10) see (RQ13)
      geom_r.heads_m1 <= devhead_r[3:0];    // see (RQ14) see (RQ18)
    end else if (soft_reset && retain_r == `IPG_RETAIN_REVERT)
      geom_r <= '0;                          // see (RQ12)
  end
  assign id_geometry = geom_r; // see (RQ11)

  // commands complete in one cycle, no wake-up wait
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r  <= 1'b0;
      rdy_r   <= 1'b0;
      abort_r <= 1'b0;
      err_r   <= 1'b0;
    end else if (cmd_wr) begin
      busy_r  <= 1'b0;                       // see (RQ3) see (RQ16)
      // ready follows completion, not spindle state, so standby commands report it too
      rdy_r   <= 1'b1;                       // see (RQ16)
      abort_r <= !(is_idle || is_imm || is_geom); // see (RQ16)
      err_r   <= !(is_idle || is_imm || is_geom);
    end
  end

  // power state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) power_r <= IPG_STANDBY;
    else if (is_idle || is_imm)
      power_r <= spindle_spinning ? IPG_IDLE : IPG_SPINUP; // see (RQ2) see (RQ8)
    else begin
      unique case (power_r)
        IPG_STANDBY: power_r <= IPG_STANDBY;
        IPG_SPINUP:  if (spindle_spinning) power_r <= IPG_IDLE;
        IPG_IDLE:    if (expire) power_r <= IPG_STANDBY; // see (RQ6)
      endcase
    end
  end

  // spin-up request held until spindle reports speed or time runs out
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) spin_cnt_r <= 32'h0;
    else if (power_r == IPG_SPINUP) spin_cnt_r <= spin_cnt_r + 32'h1;
    else spin_cnt_r <= 32'h0;
  end
  assign spin_up_req = (power_r == IPG_SPINUP) && spin_cnt_r < SPINUP_CYCLES;
  assign in_standby  = (power_r == IPG_STANDBY);
  assign spun_ev     = (power_r == IPG_SPINUP) && spindle_spinning;

  // timer runs only in idle with nonzero timeout
  ipg_timeout_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .reload (timer_reload || is_idle),                  // see (RQ1)
    .code   (is_idle ? seccnt_r : timeout_r),
    .run    (power_r == IPG_IDLE && timeout_r != 8'h00), // see (RQ4)
    .expire (expire)
  );

  // sticky interrupts: set wins over write-one clear
  assign ev = {spun_ev, expire, cmd_wr};
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) irq_stat_r <= 3'h0;
    else if (bus.wr && bus.addr == `IPG_ADDR_IRQ_STAT)
      irq_stat_r <= (irq_stat_r & ~bus.wdata[2:0]) | ev;
    else irq_stat_r <= irq_stat_r | ev;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) irq_mask_r <= 3'h0;
    else if (bus.wr && bus.addr == `IPG_ADDR_IRQ_MASK) irq_mask_r <= bus.wdata[2:0];
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // read data one cycle after strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rdata <= 8'h00;
    else if (bus.rd) begin
      unique case (bus.addr)
        `IPG_ADDR_SECCNT:   rdata <= seccnt_r;
        `IPG_ADDR_DEVHEAD:  rdata <= devhead_r;
        `IPG_ADDR_ERROR:    rdata <= {5'h00, abort_r, 2'b00};
        `IPG_ADDR_STATUS:   rdata <= {busy_r, rdy_r, 1'b0,
                                      power_r == IPG_IDLE, 3'b000, err_r};
        `IPG_ADDR_GEOM:     rdata <= geom_r.sectors;
        `IPG_ADDR_TIMEOUT:  rdata <= timeout_r;
        `IPG_ADDR_IRQ_STAT: rdata <= {5'h00, irq_stat_r};
        `IPG_ADDR_IRQ_MASK: rdata <= {5'h00, irq_mask_r};
        `IPG_ADDR_CTRL:     rdata <= retain_r;
        default:            rdata <= 8'h00;
      endcase
    end else rdata <= 8'h00;
  end

  AST_IDLE_LOADS: assert property (@(posedge mclk) disable iff (!rst_n) // see (RQ1)
    is_idle |=> timeout_r == $past(seccnt_r))
    else $error("timed idle did not load timeout");
  AST_IMM_KEEPS: assert property (@(posedge mclk) disable iff (!rst_n) // see (RQ9)
    is_imm |=> $stable(timeout_r))
    else $error("immediate idle changed timeout");
  AST_SKIP_SPIN: assert property (@(posedge mclk) disable iff (!rst_n) // see (RQ2)
    (is_idle || is_imm) && spindle_spinning |=> power_r == IPG_IDLE)
    else $error("spin-up not skipped");
  AST_SPINUP: assert property (@(posedge mclk) disable iff (!rst_n) // see (RQ8)
    is_imm && !spindle_spinning |=> spin_up_req)
    else $error("no spin-up on immediate idle");
  AST_NO_PD: assert property (@(posedge mclk) disable iff (!rst_n) // see (RQ4)
    timeout_r == 8'h00 && power_r == IPG_IDLE && !is_idle |=> power_r == IPG_IDLE)
    else $error("power-down while disabled");
  AST_GEOM: assert property (@(posedge mclk) disable iff (!rst_n) // see (RQ10)
    is_geom |=> geom_r == {$past(seccnt_r), $past(devhead_r[3:0])})
    else $error("geometry not stored");
  AST_ABORT: assert property (@(posedge mclk) disable iff (!rst_n) // see (RQ16)
    cmd_wr && !(is_idle || is_imm || is_geom) |=> abort_r && err_r && !busy_r)
    else $error("abort not reported");
  AST_DONE: assert property (@(posedge mclk) disable iff (!rst_n) // see (RQ16)
    cmd_wr |=> rdy_r && !busy_r)
    else $error("completion status not ready");
  AST_RDATA: assert property (@(posedge mclk) disable iff (!rst_n)
    !bus.rd |=> rdata == 8'h00)
    else $error("read data outside read cycle");

  COV_IDLE: cover property (@(posedge mclk) disable iff (!rst_n) is_idle);
  COV_STBY: cover property (@(posedge mclk) disable iff (!rst_n) expire);
  COV_GEOM: cover property (@(posedge mclk) disable iff (!rst_n) is_geom);
endmodule : ipg_cmd_core

// [ipg_cmd_core_tb.sv]
// self-checking bench for the command core with a host model
`timescale 1ns/100ps
module ipg_cmd_core_tb;
  import ipg_pkg::*;
  localparam int TICK = 4;
  typedef struct {
    logic [7:0]  op;
    logic [7:0]  sc;
    logic [3:0]  hd;
    logic [7:0]  err;
    logic [7:0]  st;
    logic [7:0]  tmo;
    logic [11:0] geo;
  } ipg_row_s;
  logic       mclk = 1'b0;
  logic       resetn = 1'b0;
  logic       soft_reset = 1'b0;
  logic       spindle_spinning = 1'b0;
  ipg_bus_s   bus;
  logic [7:0] rdata;
  logic [7:0] d;
  logic       spin_up_req;
  logic       in_standby;
  logic       irq;
  ipg_geom_s  id_geometry;
  int         n_fail = 0;
  int         comparisons = 0;
  int         cyc = 0;
  // small geometries keep the cylinder count in range
  ipg_row_s rows [7] = '{
    '{8'hE3, 8'h00, 4'h0, 8'h00, 8'h40, 8'h00, 12'h000},
    '{8'hE1, 8'h77, 4'h0, 8'h00, 8'h40, 8'h00, 12'h000},
    '{8'h97, 8'h00, 4'h0, 8'h00, 8'h40, 8'h00, 12'h000},
    '{8'h95, 8'h55, 4'h0, 8'h00, 8'h40, 8'h00, 12'h000},
    '{8'h91, 8'h00, 4'hF, 8'h00, 8'h40, 8'h00, 12'h00F},
    '{8'h91, 8'h3F, 4'h5, 8'h00, 8'h40, 8'h00, 12'h3F5},
    '{8'h00, 8'h12, 4'h0, 8'h04, 8'h41, 8'h00, 12'h3F5}};
  logic [7:0] tcode [4] = '{8'h01, 8'hF0, 8'hF1, 8'hFC};
  int         tsec [4] = '{5, 1200, 1800, 1260};
  always #12.5 mclk = ~mclk;
  ipg_cmd_core #(.TICK_CYCLES(TICK), .SPINUP_CYCLES(8)) ipg_cmd_core_inst (
    .mclk(mclk), .resetn(resetn), .bus(bus), .rdata(rdata), .soft_reset(soft_reset),
    .spindle_spinning(spindle_spinning), .spin_up_req(spin_up_req),
    .in_standby(in_standby), .id_geometry(id_geometry), .irq(irq));
  ipg_host_model ipg_host_model_inst (.mclk(mclk), .bus(bus), .rdata(rdata));
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    ipg_host_model_inst.rd(a, d);
    chk(nm, e, d & m);
  endtask : rdc
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // run should end near 17400 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    #1 chk("reset standby", 12'h001, in_standby);
    chk("reset geometry", 12'h000, id_geometry);
    chk("reset irq", 12'h000, irq);
    rdc("retain", 4'h9, 8'hFF, 8'h66);
    $display("reset test done");
    // spindle stopped: idle immediate has to spin up
    ipg_host_model_inst.issue(8'hE1, 8'h00, 4'h0);
    @(posedge mclk);
    #1 chk("spin up", 12'h001, spin_up_req);
    chk("left standby", 12'h000, in_standby);
    // no speed report: the request gives up after its limit, state stays in spin-up
    repeat (8) @(posedge mclk);
    #1 chk("spin-up limit", 12'h000, spin_up_req);
    chk("still left standby", 12'h000, in_standby);
    @(posedge mclk);
    spindle_spinning <= 1'b1;
    repeat (10) @(posedge mclk);
    #1 chk("spun up", 12'h000, spin_up_req);
    rdc("spun up status", 4'h4, 8'h50, 8'h50);
    rdc("done event", 4'h7, 8'h01, 8'h01);
    ipg_host_model_inst.wr(4'h8, 8'h01);
    @(posedge mclk);
    #1 chk("irq unmasked", 12'h001, irq);
    ipg_host_model_inst.wr(4'h7, 8'hFF);
    @(posedge mclk);
    #1 chk("irq cleared", 12'h000, irq);
    ipg_host_model_inst.wr(4'h8, 8'h00);
    $display("spin-up and irq test done");
    foreach (rows[i]) begin
      ipg_host_model_inst.issue(rows[i].op, rows[i].sc, rows[i].hd);
      rdc("error", 4'h3, 8'hFF, rows[i].err);
      rdc("status", 4'h4, 8'hC1, rows[i].st);
      rdc("timeout", 4'h6, 8'hFF, rows[i].tmo);
      chk("geometry", rows[i].geo, id_geometry);
      chk("idle", 12'h000, in_standby);
      $display("row %0d done", i);
    end
    chk("irq masked", 12'h000, irq);
    repeat (40) @(posedge mclk);
    #1 chk("zero timeout", 12'h000, in_standby);
    // retain option decides whether a soft reset drops the geometry
    for (int j = 0; j < 2; j++) begin
      if (j == 1) ipg_host_model_inst.wr(4'h9, 8'hCC);
      @(posedge mclk);
      soft_reset <= 1'b1;
      @(posedge mclk);
      soft_reset <= 1'b0;
      repeat (2) @(posedge mclk);
      #1 chk("soft reset geometry", (j == 1) ? 12'h000 : 12'h3F5, id_geometry);
    end
    $display("soft reset test done");
    foreach (tcode[k]) begin
      ipg_host_model_inst.issue(8'hE3, tcode[k], 4'h0);
      #1 chk("no spin-up", 12'h000, spin_up_req);
      if (k == 0) begin
        repeat (12) @(posedge mclk);
        ipg_host_model_inst.wr(4'h1, 8'h00);
      end
      repeat (tsec[k] * TICK - 8) @(posedge mclk);
      #1 chk("before expiry", 12'h000, in_standby);
      repeat (16) @(posedge mclk);
      #1 chk("after expiry", 12'h001, in_standby);
      rdc("standby event", 4'h7, 8'h02, 8'h02);
      ipg_host_model_inst.wr(4'h7, 8'hFF);
      $display("timer code %h done", tcode[k]);
    end
    // eight-hour code is only loaded; its length is left to the decode assertion
    ipg_host_model_inst.issue(8'hE3, 8'hFD, 4'h0);
    rdc("long timeout", 4'h6, 8'hFF, 8'hFD);
    $display("long timeout test done");
    // mid-run reset brings back power-on state; geometry is then taken in standby
    ipg_host_model_inst.issue(8'h91, 8'h20, 4'h3);
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    #1 chk("rerun standby", 12'h001, in_standby);
    chk("rerun geometry", 12'h000, id_geometry);
    rdc("rerun timeout", 4'h6, 8'hFF, 8'h00);
    rdc("rerun retain", 4'h9, 8'hFF, 8'h66);
    ipg_host_model_inst.issue(8'h91, 8'h20, 4'h3);
    rdc("standby status", 4'h4, 8'hC1, 8'h40);
    chk("standby geometry", 12'h203, id_geometry);
    chk("still standby", 12'h001, in_standby);
    $display("mid-run reset test done");
    final_report();
  end
endmodule : ipg_cmd_core_tb

// [ipg_defines.svh]
// constants for the idle, power-down and geometry command block
`ifndef IPG_DEFINES_SVH
`define IPG_DEFINES_SVH

`define IPG_OP_IDLE_A        8'hE3
`define IPG_OP_IDLE_B        8'h97
`define IPG_OP_IDLE_IMM_A    8'hE1
`define IPG_OP_IDLE_IMM_B    8'h95
`define IPG_OP_GEOM          8'h91

`define IPG_ADDR_CMD         4'h0
`define IPG_ADDR_SECCNT      4'h1
`define IPG_ADDR_DEVHEAD     4'h2
`define IPG_ADDR_ERROR       4'h3
`define IPG_ADDR_STATUS      4'h4
`define IPG_ADDR_GEOM        4'h5
`define IPG_ADDR_TIMEOUT     4'h6
`define IPG_ADDR_IRQ_STAT    4'h7
`define IPG_ADDR_IRQ_MASK    4'h8
`define IPG_ADDR_CTRL        4'h9

`define IPG_ERR_ABORT_BIT    2
`define IPG_ST_BUSY_BIT      7
`define IPG_ST_READY_BIT     6
`define IPG_ST_SEEK_BIT      4
`define IPG_ST_ERR_BIT       0

`define IPG_RETAIN_KEEP      8'h66
`define IPG_RETAIN_REVERT    8'hCC

`define IPG_IRQ_DONE_BIT     0
`define IPG_IRQ_STANDBY_BIT  1
`define IPG_IRQ_SPUN_BIT     2

// one tick per second of timeout, 40 MHz clock
`define IPG_CLK_HZ           40000000
`define IPG_TICK_SEC         1
`define IPG_TICK_CYCLES      (`IPG_CLK_HZ * `IPG_TICK_SEC)
// values 1-240 count in units of 5 seconds
`define IPG_UNIT_SEC         5
`define IPG_HALF_HOUR_SEC    1800
`define IPG_SEC_252          1260
`define IPG_SEC_253          28800
`define IPG_SEC_254          1270
`define IPG_SEC_255          1275
`define IPG_SPINUP_MS        100
`define IPG_SPINUP_CYCLES    ((`IPG_CLK_HZ / 1000) * `IPG_SPINUP_MS)

`endif

// [ipg_host_model.sv]
// host adapter model driving the command-block register port
`timescale 1ns/100ps
module ipg_host_model (
  // clock
  input  wire logic         mclk,
  // register port
  output ipg_pkg::ipg_bus_s bus,
  input  wire logic [7:0]   rdata
);
  import ipg_pkg::*;
  initial bus = '0;
  // one strobe cycle, then released lines flip so stale values never look valid
  task automatic put(input logic [3:0] a, input logic [7:0] d, input logic w);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge mclk);
    bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask : put
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    put(a, d, 1'b1);
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    put(a, 8'h00, 1'b0);
    #1 d = rdata;
  endtask : rd
  // device/head carries its fixed ones and device 0 before the opcode
  task automatic issue(input logic [7:0] op, input logic [7:0] sc, input logic [3:0] hd);
    wr(4'h1, sc);
    wr(4'h2, {4'hA, hd});
    wr(4'h0, op);
  endtask : issue
endmodule : ipg_host_model

// [ipg_pkg.sv]
// types for the idle, power-down and geometry command block
package ipg_pkg;
  typedef enum logic [1:0] {IPG_STANDBY, IPG_SPINUP, IPG_IDLE} ipg_power_e;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ipg_bus_s;
  typedef struct packed {
    logic [7:0] sectors;
    logic [3:0] heads_m1;
  } ipg_geom_s;
endpackage : ipg_pkg

// [ipg_timeout_timer.sv]
// auto power-down countdown in seconds with reload
`timescale 1ns/100ps
`include "ipg_defines.svh"
module ipg_timeout_timer #(
  parameter int unsigned TICK_CYCLES = `IPG_TICK_CYCLES
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // control
  input  wire logic        reload,
  input  wire logic [7:0]  code,
  input  wire logic        run,
  // result
  output logic             expire
);
  import ipg_pkg::*;

  logic [31:0] tick_cnt_r;
  logic [15:0] sec_cnt_r;
  logic        tick;

  // decode the timeout code into seconds
  function automatic logic [15:0] ipg_decode(input logic [7:0] v);
    logic [15:0] s;
    s = 16'h0000;
    if (v >= 8'hF1 && v <= 8'hFB)
      s = 16'(({8'h00, v} - 16'h00F0) * `IPG_HALF_HOUR_SEC);
    else if (v == 8'hFC) s = 16'(`IPG_SEC_252);
    else if (v == 8'hFD) s = 16'(`IPG_SEC_253);
    else if (v == 8'hFE) s = 16'(`IPG_SEC_254);
    else if (v == 8'hFF) s = 16'(`IPG_SEC_255);
    else s = 16'({8'h00, v} * `IPG_UNIT_SEC);
    return s;
  endfunction : ipg_decode

  assign tick = (tick_cnt_r == TICK_CYCLES - 1);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) tick_cnt_r <= 32'h0;
    else if (reload || tick) tick_cnt_r <= 32'h0;
    else if (run) tick_cnt_r <= tick_cnt_r + 32'h1;
  end

  // reload restarts the full interval; zero code leaves it stopped
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) sec_cnt_r <= 16'h0;
    else if (reload) sec_cnt_r <= ipg_decode(code); // see (RQ5) see (RQ7)
    else if (run && tick && sec_cnt_r != 16'h0) sec_cnt_r <= sec_cnt_r - 16'h1;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) expire <= 1'b0;
    else expire <= run && !reload && tick && (sec_cnt_r == 16'h1); // see (RQ6)
  end

  AST_DECODE_253: assert property (@(posedge mclk) disable iff (!rst_n) // see (RQ5)
    reload && code == 8'hFD |=> sec_cnt_r == 16'h7080)
    else $error("code 253 not eight hours");
  AST_DECODE_241: assert property (@(posedge mclk) disable iff (!rst_n) // see (RQ5)
    reload && code == 8'hF1 |=> sec_cnt_r == 16'h0708)
    else $error("code 241 not half hour");
endmodule : ipg_timeout_timer
